/* hdl/sinc3_pkg.sv */
package sinc3_pkg;
  // ---------------------------------------------------------------
  // Data format
  // ---------------------------------------------------------------
  localparam int SAMPLE_W   = 24;
  localparam int CHANNELS   = 8;
  localparam logic [23:0] CODE_MAX  = 24'h7FFFFF;  // Positive clip
  localparam logic [23:0] CODE_MIN  = 24'h800000;  // Negative clip
  // Insignificant low bits in the two coarse rate settings
  localparam int DROP_RATE0 = 7;
  localparam int DROP_RATE1 = 5;
  // ---------------------------------------------------------------
  // Rates and timing
  // ---------------------------------------------------------------
  localparam int MOD_DIV_HR = 4;   // Modulator tick in high-resolution mode
  localparam int MOD_DIV_LP = 8;   // Modulator tick in low-power mode
  localparam int SETTLE_PERIODS = 3;  // Output periods for filter memory
  localparam int DR_W       = 3;
  localparam logic [2:0] DR_RATE0 = 3'h0;
  localparam logic [2:0] DR_RATE1 = 3'h1;
  // Base decimation ratio at setting 000; each step halves it
  localparam int DEC_BASE_LOG2 = 10;
  localparam int ACC_W      = 3 * DEC_BASE_LOG2 + 2;
endpackage : sinc3_pkg

/* hdl/sample_store.sv */
`timescale 1ns/1ps
`default_nettype none
// Channel result memory: registered read port, one write per cycle
module sample_store #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 24
) (
  // Clock
  input  wire logic                     ref_clk,
  // Write port
  input  wire logic                     writeEn,
  input  wire logic [$clog2(DEPTH)-1:0] writeAddr,
  input  wire logic [WIDTH-1:0]         writeData,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] readAddr,
  output logic      [WIDTH-1:0]         readData
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];  // One word per channel

  // Write and registered read
  always_ff @(posedge ref_clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
    readData <= mem[readAddr];
  end
endmodule : sample_store
`default_nettype wire

/* hdl/sinc3_decimator.sv */
`timescale 1ns/1ps
`default_nettype none
module sinc3_decimator #(
  parameter int CHANNELS = sinc3_pkg::CHANNELS
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Clock source control
  input  wire logic                  clock_source_select_pin,
  input  wire logic                  clockOutEnable,
  input  wire logic                  oscClock,
  output logic                       clockPinOut,
  output logic                       clockPinOe,
  output logic                       useInternalClock,
  // Configuration
  input  wire logic [2:0]            data_rate_select,
  input  wire logic                  lowPowerMode,
  input  wire logic                  reference_high_select,
  input  wire logic                  reference_buffer_power,
  input  wire logic                  startConv,
  output logic                       refHighActive,
  output logic                       refBufferOn,
  // Modulator bitstreams
  input  wire logic [CHANNELS-1:0]   modBits,
  // Results toward the serial port
  input  wire logic [$clog2(CHANNELS)-1:0] readChannel,
  output logic [23:0]                readSample,
  input  wire logic                  dataTaken,
  output logic                       data_ready_n,
  output logic                       settled
);
  localparam int AW = sinc3_pkg::ACC_W;
  localparam int CW = $clog2(CHANNELS);
  localparam int DW = sinc3_pkg::DEC_BASE_LOG2;  // Decimation counter width

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Decimation ratio log2 for a rate code
  function automatic int unsigned decLog2(input logic [2:0] dr);
    decLog2 = sinc3_pkg::DEC_BASE_LOG2 - int'(dr);
  endfunction : decLog2

  // Saturate, scale and mask a raw sinc3 sum to 24 bits
  function automatic logic [23:0] formatSample(input logic signed [AW-1:0] raw,
                                               input logic [2:0] dr);
    logic signed [AW-1:0] shifted;
    logic signed [AW-1:0] centered;
    logic [23:0]          res;
    int                   sh;
    shifted  = '0;
    centered = '0;
    res      = '0;
    sh       = 3 * int'(decLog2(dr));
    // Gain N^3 spans full scale: centre it, then put its half-span at 2^23
    centered = raw - (AW'(1) <<< (sh - 1));
    shifted  = (sh > sinc3_pkg::SAMPLE_W) ? (centered >>> (sh - sinc3_pkg::SAMPLE_W))
                                          : (centered <<< (sinc3_pkg::SAMPLE_W - sh));
    if (shifted > $signed(AW'(23'h7FFFFF))) begin
      res = sinc3_pkg::CODE_MAX;
    end else if (shifted < -$signed(AW'(24'h800000))) begin
      res = sinc3_pkg::CODE_MIN;
    end else begin
      res = shifted[23:0];
      // clear insignificant bits; clip codes keep all 24 bits
      if (dr == sinc3_pkg::DR_RATE0) begin
        res[sinc3_pkg::DROP_RATE0-1:0] = '0;
      end else if (dr == sinc3_pkg::DR_RATE1) begin
        res[sinc3_pkg::DROP_RATE1-1:0] = '0;
      end
    end
    formatSample = res;
  endfunction : formatSample

  // ---------------------------------------------------------------
  // Clock source
  // ---------------------------------------------------------------
  // select low uses external input, pin never driven
  // select high drives oscillator out only when enabled
  assign useInternalClock = clock_source_select_pin;
  assign clockPinOe       = clock_source_select_pin & clockOutEnable;
  assign clockPinOut      = clockPinOe & oscClock;

  // ---------------------------------------------------------------
  // Reference control
  // ---------------------------------------------------------------
  // 4V only when selected
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      refHighActive <= 1'b0;
      refBufferOn   <= 1'b0;
    end else begin
      refHighActive <= reference_high_select;
      refBufferOn   <= reference_buffer_power;
    end
  end

  // ---------------------------------------------------------------
  // Modulator tick
  // ---------------------------------------------------------------
  logic [2:0] tickCnt;   // Divider for modulator rate
  logic       modTick;   // One cycle per modulator period
  logic       startSync1, startSync2, startPrev;  // Start pin synchroniser
  logic [CHANNELS-1:0] modSync1, modSync2;         // Bitstream synchroniser

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tickCnt <= 3'h0;
    end else if (modTick) begin
      tickCnt <= 3'h0;
    end else begin
      tickCnt <= tickCnt + 3'h1;
    end
  end
  assign modTick = lowPowerMode ? (tickCnt == 3'(sinc3_pkg::MOD_DIV_LP - 1))
                                : (tickCnt == 3'(sinc3_pkg::MOD_DIV_HR - 1));

  // Pins pass two flops before use
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      startSync1 <= 1'b0;
      startSync2 <= 1'b0;
      startPrev  <= 1'b0;
      modSync1   <= '0;
      modSync2   <= '0;
    end else begin
      startSync1 <= startConv;
      startSync2 <= startSync1;
      startPrev  <= startSync2;
      modSync1   <= modBits;
      modSync2   <= modSync1;
    end
  end

  logic startRise;  // Conversion restart request
  assign startRise = startSync2 & ~startPrev;

  // ---------------------------------------------------------------
  // Decimation counter
  // ---------------------------------------------------------------
  logic [sinc3_pkg::DEC_BASE_LOG2-1:0] decCnt;   // Modulator samples in period
  logic                                decEnd;   // Last sample of period
  logic [2:0]                          drHeld;   // Rate code in use

  // one common rate for every channel
  assign decEnd = modTick &&
    (decCnt == DW'((1 << decLog2(drHeld)) - 1));

  always_ff @(posedge ref_clk) begin
    if (srst || startRise) begin
      decCnt <= '0;
      drHeld <= data_rate_select;
    end else if (decEnd) begin
      decCnt <= '0;
      drHeld <= data_rate_select;
    end else if (modTick) begin
      decCnt <= decCnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Sinc3 integrators and combs per channel
  // ---------------------------------------------------------------
  logic signed [AW-1:0] int1 [CHANNELS];
  logic signed [AW-1:0] int2 [CHANNELS];
  logic signed [AW-1:0] int3 [CHANNELS];
  logic signed [AW-1:0] d1 [CHANNELS];   // Comb delays
  logic signed [AW-1:0] d2 [CHANNELS];
  logic signed [AW-1:0] d3 [CHANNELS];
  logic signed [AW-1:0] combOut [CHANNELS];

  // integrate at modulator rate, comb at output rate
  always_ff @(posedge ref_clk) begin
    if (srst || startRise) begin
      for (int c = 0; c < CHANNELS; c++) begin
        int1[c] <= '0;
        int2[c] <= '0;
        int3[c] <= '0;
        d1[c] <= '0;
        d2[c] <= '0;
        d3[c] <= '0;
        combOut[c] <= '0;
      end
    end else if (modTick) begin
      for (int c = 0; c < CHANNELS; c++) begin
        int1[c] <= int1[c] + AW'(modSync2[c]);
        int2[c] <= int2[c] + int1[c];
        int3[c] <= int3[c] + int2[c];
        // every channel decimated on the same tick
        if (decEnd) begin
          d1[c] <= int3[c];
          d2[c] <= int3[c] - d1[c];
          d3[c] <= int3[c] - d1[c] - d2[c];
          combOut[c] <= int3[c] - d1[c] - d2[c] - d3[c];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Settling and capture
  // ---------------------------------------------------------------
  logic [1:0] periodCnt;   // Output periods since restart
  logic       capturing;   // Writing results to memory
  logic [CW-1:0] capIdx;   // Channel being written

  always_ff @(posedge ref_clk) begin
    if (srst || startRise) begin
      periodCnt <= 2'h0;
    end else if (decEnd && periodCnt != 2'(sinc3_pkg::SETTLE_PERIODS)) begin
      periodCnt <= periodCnt + 2'h1;
    end
  end
  assign settled = (periodCnt == 2'(sinc3_pkg::SETTLE_PERIODS));

  // Copy all channels into the store after each settled period
  always_ff @(posedge ref_clk) begin
    if (srst || startRise) begin
      capturing <= 1'b0;
      capIdx    <= '0;
    end else if (decEnd && settled) begin
      capturing <= 1'b1;
      capIdx    <= '0;
    end else if (capturing) begin
      capIdx    <= capIdx + 1'b1;
      capturing <= (capIdx != CW'(CHANNELS - 1));
    end
  end

  // 24-bit words held for the serial shifter
  sample_store #(
    .DEPTH (CHANNELS),
    .WIDTH (sinc3_pkg::SAMPLE_W)
  ) u_store (
    .ref_clk   (ref_clk),
    .writeEn   (capturing),
    .writeAddr (capIdx),
    .writeData (formatSample(combOut[capIdx], drHeld)),
    .readAddr  (readChannel),
    .readData  (readSample)
  );

  // ready low once the whole set is stored
  // the serial port clears it when data is taken
  always_ff @(posedge ref_clk) begin
    if (srst || startRise) begin
      data_ready_n <= 1'b1;
    end else if (capturing && capIdx == CW'(CHANNELS - 1)) begin
      data_ready_n <= 1'b0;
    end else if (dataTaken) begin
      data_ready_n <= 1'b1;
    end
  end
endmodule : sinc3_decimator
`default_nettype wire

/* bench/sinc3_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module sinc3_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Clock pin
  input wire logic clock_source_select_pin,
  input wire logic clockOutEnable,
  input wire logic oscClock,
  input wire logic clockPinOut,
  input wire logic clockPinOe,
  input wire logic useInternalClock,
  // Reference and results
  input wire logic reference_high_select,
  input wire logic reference_buffer_power,
  input wire logic refHighActive,
  input wire logic refBufferOn,
  input wire logic startConv,
  input wire logic dataTaken,
  input wire logic data_ready_n,
  input wire logic settled
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Pin is driven only by oscillator with enable
  a_pin_drive_gate: assert property (
    clockPinOe == (clock_source_select_pin && clockOutEnable)) else $error("pin enable wrong");
  a_pin_carries_osc: assert property (
    clockPinOe |-> clockPinOut == oscClock) else $error("pin not oscillator");
  a_source_follows_pin: assert property (
    useInternalClock == clock_source_select_pin) else $error("clock source wrong");
  // Copies skip the first edge after reset
  a_ref_high_copy: assert property (
    !$past(srst) |-> refHighActive == $past(reference_high_select)) else $error("ref high");
  a_buffer_copy: assert property (
    !$past(srst) |-> refBufferOn == $past(reference_buffer_power)) else $error("buffer bit");
  a_ready_needs_settle: assert property (
    $fell(data_ready_n) |-> settled) else $error("ready before settled");
  // Start is synchronised, so look three edges back
  a_ready_stands_low: assert property (
    !data_ready_n && !dataTaken && $stable(startConv) && startConv == $past(startConv, 2)
    && startConv == $past(startConv, 3) |=> !data_ready_n) else $error("ready dropped");
  a_start_withholds: assert property (
    $rose(startConv) |-> ##[3:6] (data_ready_n && !settled)) else $error("start not seen");
  c_ready_fall: cover property ($fell(data_ready_n));
  c_pin_driven: cover property (clockPinOe);
  c_settled: cover property ($rose(settled));
endmodule : sinc3_chk
bind sinc3_decimator sinc3_chk u_chk (.ref_clk, .srst, .clock_source_select_pin,
  .clockOutEnable, .oscClock, .clockPinOut, .clockPinOe, .useInternalClock,
  .reference_high_select, .reference_buffer_power, .refHighActive, .refBufferOn,
  .startConv, .dataTaken, .data_ready_n, .settled);
`default_nettype wire

/* bench/host_reader.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Host reading each result set
// ------------------------------
module host_reader (
  // Clock and control
  input wire logic ref_clk,
  input wire logic hostOn,
  // Result port
  input wire logic data_ready_n,
  input wire logic [23:0] readSample,
  output logic [2:0] readChannel,
  output logic dataTaken
);
  logic [23:0] got [8];  // Last set read
  int sets = 0;  // Sets read so far
  initial begin
    readChannel = 3'h0;
    dataTaken = 1'b0;
    forever begin
      @(negedge ref_clk);
      // Stalls while disabled, so ready must stand
      if (hostOn && data_ready_n === 1'b0) begin
        for (int k = 0; k < 8; k++) begin
          readChannel = k[2:0];
          @(negedge ref_clk);
          got[k] = readSample;
        end
        dataTaken = 1'b1;
        @(negedge ref_clk);
        dataTaken = 1'b0;
        sets++;
      end
    end
  end
endmodule : host_reader
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------
  // Stimulus and observation
  // ------------------------------
  logic ref_clk = 1'b0, srst = 1'b1, clock_source_select_pin = 1'b0, clockOutEnable = 1'b0;
  logic oscClock = 1'b0, lowPowerMode = 1'b0, reference_high_select = 1'b0, startConv = 1'b0;
  logic reference_buffer_power = 1'b0, hostOn = 1'b0;
  logic [2:0] data_rate_select = 3'h6;  // Short periods
  logic [7:0] modBits = 8'h00;
  logic [2:0] readChannel;
  logic [23:0] readSample;
  logic dataTaken, data_ready_n, settled, clockPinOut, clockPinOe;
  logic useInternalClock, refHighActive, refBufferOn;
  int bad_count = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  always #3 oscClock = ~oscClock;  // Unrelated oscillator
  sinc3_decimator u_sinc3_decimator (.ref_clk, .srst, .clock_source_select_pin,
    .clockOutEnable, .oscClock, .clockPinOut, .clockPinOe, .useInternalClock,
    .data_rate_select, .lowPowerMode, .reference_high_select, .reference_buffer_power,
    .startConv, .refHighActive, .refBufferOn, .modBits, .readChannel, .readSample,
    .dataTaken, .data_ready_n, .settled);
  host_reader u_host_reader (.ref_clk, .hostOn, .data_ready_n, .readSample, .readChannel,
    .dataTaken);
  // Compare and count
  task check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // Bounded wait for ready low
  task wait_fall(output int n);
    n = 0;
    while (data_ready_n !== 1'b0) begin
      @(negedge ref_clk);
      n++;
      if (n > 17000) begin
        bad_count++;
        final_report();
      end
    end
  endtask : wait_fall
  // Clock pin truth table, select/enable rows 01 to 11
  task t_clock;
    for (int c = 1; c < 4; c++) begin
      @(negedge ref_clk);
      {clock_source_select_pin, clockOutEnable} = c[1:0];
      #1;
      check(useInternalClock, c[1]);
      check(clockPinOe, c == 3);
    end
    // Look between oscillator edges, at both levels
    repeat (2) begin
      @(oscClock);
      #1;
      check(clockPinOut, oscClock);
    end
    @(negedge ref_clk);
  endtask : t_clock
  // Reference bits from reset
  task t_refs;
    check({refHighActive, refBufferOn, data_ready_n}, 3'h1);
    {reference_high_select, reference_buffer_power} = 2'h3;
    repeat (2) @(negedge ref_clk);
    check({refHighActive, refBufferOn}, 2'h3);
    reference_high_select = 1'b0;  // Low supply keeps 2.4V
  endtask : t_refs
  // Restart, settle, read a set, measure the period
  task t_stream(input logic [7:0] pat, input logic lp, input logic [2:0] rate);
    int n, p, s0;
    time t1;
    p = (1 << (sinc3_pkg::DEC_BASE_LOG2 - rate))
      * (lp ? sinc3_pkg::MOD_DIV_LP : sinc3_pkg::MOD_DIV_HR);
    {modBits, lowPowerMode, data_rate_select, hostOn} = {pat, lp, rate, 1'b1};
    startConv = 1'b0;
    repeat (4) @(negedge ref_clk);
    startConv = 1'b1;
    // Restart passes the synchroniser, then an old set must be withdrawn
    repeat (4) @(negedge ref_clk);
    check(data_ready_n, 1'b1);
    wait_fall(n);
    n = n + 4;
    s0 = u_host_reader.sets;
    check(n > 3 * p && n <= 4 * p + 20, 1'b1);
    check(settled, 1'b1);
    t1 = $time;
    for (int i = 0; i < 40 && u_host_reader.sets == s0; i++) @(negedge ref_clk);
    for (int k = 0; k < 8; k++)
      check(u_host_reader.got[k], pat[k] ? sinc3_pkg::CODE_MAX : sinc3_pkg::CODE_MIN);
    check(data_ready_n, 1'b1);
    wait_fall(n);
    check(24'(($time - t1) / 10), 24'(p));
  endtask : t_stream
  // Stalled host leaves ready low
  task t_hold;
    int n;
    // Let the host take the set in flight, then stall it
    repeat (20) @(negedge ref_clk);
    hostOn = 1'b0;
    check(data_ready_n, 1'b1);
    wait_fall(n);
    // Longer than a period: a new set keeps ready low
    repeat (300) @(negedge ref_clk);
    check(data_ready_n, 1'b0);
    hostOn = 1'b1;
  endtask : t_hold
  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    t_refs();
    t_clock();
    t_stream(8'h0F, 1'b0, 3'h6);
    t_stream(8'h3C, 1'b0, 3'h0);
    t_stream(8'hA5, 1'b1, 3'h5);
    t_hold();
    final_report();
  end
endmodule : tb
`default_nettype wire
